// ---- hdl/mrx_pkg.sv ----
// Shared constants and carrier types for the receive mode and data registers.
package mrx_pkg;

   // ********************************************************************
   // Serial bus addresses
   // ********************************************************************
   localparam logic [7:0] ADDR_GRESET = 8'h01;
   localparam logic [7:0] ADDR_GCTL = 8'hE0;
   localparam logic [7:0] ADDR_RXCFG = 8'hE2;
   localparam logic [7:0] ADDR_TXB = 8'hE3;
   localparam logic [7:0] ADDR_TXB_OS = 8'hE4;
   localparam logic [7:0] ADDR_RXB = 8'hE5;

   // ********************************************************************
   // Field positions, codes and reset values
   // ********************************************************************
   localparam int GCTL_RST_BIT = 7;
   localparam logic [15:0] RXCFG_RESET = 16'h0000;
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TONE = 4'h1;
   localparam logic [3:0] MODE_DPSK_MIN = 4'hA;
   localparam logic [3:0] MODE_DPSK_MAX = 4'hD;
   localparam logic [2:0] USART_SYNC = 3'h7;
   localparam logic [2:0] USART_OS8 = 3'h5;
   localparam logic [2:0] USART_OS4 = 3'h4;
   localparam logic [3:0] LEN_BASE = 4'h5;
   localparam logic [3:0] LEN_SYNC = 4'h8;
   localparam logic [3:0] OS8_GOOD = 4'h7;
   localparam logic [3:0] OS4_GOOD = 4'h3;

   // ********************************************************************
   // Serial frame edge counts
   // ********************************************************************
   localparam logic [4:0] SER_ADDR_LAST = 5'h07;
   localparam logic [4:0] SER_BYTE_LAST = 5'h0F;
   localparam logic [4:0] SER_WORD_LAST = 5'h17;
   localparam logic [4:0] SER_RD_TOP = 5'h0E;

   typedef struct packed {
      logic [3:0] mode;
      logic [2:0] gain;
      logic eq;
      logic [1:0] desc;
      logic [2:0] usart;
      logic [2:0] fmt;
   } mrx_rx_cfg_t;

   typedef struct packed {
      logic sync;
      logic [1:0] len;
      logic par_en;
      logic par_odd;
      logic two_stop;
   } mrx_tx_fmt_t;

   typedef struct packed {
      logic ready;
      logic overflow;
      logic framing_error;
      logic even_parity;
   } mrx_rx_stat_t;

endpackage

// ---- hdl/mrx_tgl_sync.sv ----
// Toggle synchroniser that turns a toggle from another clock into a pulse.
module mrx_tgl_sync (
   input wire logic clk,
   input wire logic tgl_in,
   output logic pulse
);
   logic meta_q = 1'b0;
   logic sync_q = 1'b0;
   logic prev_q = 1'b0;

   always_ff @(posedge clk) begin
      meta_q <= tgl_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
   end

   assign pulse = sync_q ^ prev_q;
endmodule

// ---- hdl/mrx_rx_usart.sv ----
// Receive character assembler for synchronous and start-stop data.
module mrx_rx_usart (
   input wire logic ref_clk,
   input wire logic rst,
   input wire mrx_pkg::mrx_rx_cfg_t cfg,
   input wire logic bit_in,
   input wire logic bit_stb,
   output logic char_stb,
   output logic [7:0] char_data,
   output logic framing_err,
   output logic even_par
);
   typedef enum {ST_IDLE, ST_DATA, ST_PAR, ST_STOP} mrx_rx_st_t;
   mrx_rx_st_t st_q;
   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic [3:0] good_q;
   logic par_q;

   wire sync_mode = cfg.usart == mrx_pkg::USART_SYNC;
   wire active = cfg.usart[2] && cfg.mode != mrx_pkg::MODE_OFF &&
      cfg.mode != mrx_pkg::MODE_TONE;
   wire dpsk = cfg.mode >= mrx_pkg::MODE_DPSK_MIN &&
      cfg.mode <= mrx_pkg::MODE_DPSK_MAX;
   wire [3:0] n_bits = sync_mode ? mrx_pkg::LEN_SYNC :
      mrx_pkg::LEN_BASE + {2'h0, cfg.fmt[2:1]};
   wire tol_ok = dpsk &&
      ((cfg.usart == mrx_pkg::USART_OS8 && good_q >= mrx_pkg::OS8_GOOD) ||
      (cfg.usart == mrx_pkg::USART_OS4 && good_q >= mrx_pkg::OS4_GOOD));
   wire [7:0] sh_next = {bit_in, sh_q[7:1]};
   wire last_bit = cnt_q == n_bits - 4'h1;

   always_ff @(posedge ref_clk) begin
      char_stb <= 1'b0;
      framing_err <= 1'b0;
      if (rst || !active) begin
         st_q <= ST_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         good_q <= 4'h0;
         par_q <= 1'b0;
         if (rst) begin
            char_data <= 8'h00;
            even_par <= 1'b0;
         end
      end else if (bit_stb && sync_mode) begin
         // Earliest bit ends up in bit 0.
         sh_q <= sh_next;
         cnt_q <= last_bit ? 4'h0 : cnt_q + 4'h1;
         if (last_bit) begin
            char_data <= sh_next;
            char_stb <= 1'b1;
         end
      end else if (bit_stb) begin
         case (st_q)
            ST_IDLE: begin
               if (!bit_in) begin
                  st_q <= ST_DATA;
                  cnt_q <= 4'h0;
                  par_q <= 1'b0;
               end
            end
            ST_DATA: begin
               sh_q <= sh_next;
               par_q <= par_q ^ bit_in;
               cnt_q <= cnt_q + 4'h1;
               if (last_bit) begin
                  st_q <= cfg.fmt[0] ? ST_PAR : ST_STOP;
               end
            end
            ST_PAR: begin
               even_par <= ~(par_q ^ bit_in);
               st_q <= ST_STOP;
            end
            ST_STOP: begin
               // First bit in bit 0, unused upper bits zero.
               char_data <= sh_q >> (mrx_pkg::LEN_SYNC - n_bits);
               char_stb <= 1'b1;
               cnt_q <= 4'h0;
               par_q <= 1'b0;
               if (bit_in) begin
                  st_q <= ST_IDLE;
                  good_q <= (good_q == 4'hF) ? good_q : good_q + 4'h1;
               end else if (tol_ok) begin
                  // A missing stop bit is taken as the next start bit.
                  st_q <= ST_DATA;
                  good_q <= 4'h0;
               end else begin
                  st_q <= ST_IDLE;
                  framing_err <= 1'b1;
                  good_q <= 4'h0;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ********************************************************************
   // Assertions
   // ********************************************************************
   property p_upper_zero;
      @(posedge ref_clk) disable iff (rst)
      char_stb && !sync_mode && cfg.fmt[2:1] == 2'h0 |->
         char_data[7:5] == 3'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("Unused receive data bits not zero.");

   property p_stop_fe;
      @(posedge ref_clk) disable iff (rst)
      active && !sync_mode && st_q == ST_STOP && bit_stb && !bit_in &&
         !tol_ok |=> framing_err && char_stb;
   endproperty
   a_stop_fe: assert property (p_stop_fe)
      else $error("Missing stop bit did not flag a framing error.");
endmodule

// ---- hdl/mrx_top.sv ----
// Receive mode register, data registers and serial control bus slave.

module mrx_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ser_clk,
   input wire logic ser_cs_n,
   input wire logic ser_din,
   output logic ser_dout,
   input wire mrx_pkg::mrx_tx_fmt_t tx_fmt,
   input wire logic tx_bit_stb,
   output logic tx_bit,
   output logic tx_ready,
   input wire logic demod_bit,
   input wire logic demod_bit_stb,
   output mrx_pkg::mrx_rx_cfg_t rx_cfg,
   output logic auto_equaliser_enable,
   output logic descrambler_enable,
   output logic ones64_detect_enable,
   output logic tone_detect_active,
   output logic [2:0] tone_detector_select,
   output mrx_pkg::mrx_rx_stat_t rx_status
);
   // ********************************************************************
   // Serial bus slave, link clock domain
   // ********************************************************************
   logic [4:0] cnt_q;
   logic [7:0] addr_q;
   logic [15:0] dat_q;
   logic ser_dout_q;
   logic [7:0] wr_addr_q;
   logic [15:0] wr_data_q;
   logic wr_tgl_q = 1'b0;
   logic rd_tgl_q = 1'b0;
   logic ack_tgl_q = 1'b0;
   logic [7:0] snap_q = 8'h00;
   logic pub_pulse;
   logic pub_tgl_q;
   logic [7:0] pub_word_q;

   wire [7:0] addr_now = {addr_q[6:0], ser_din};
   wire [15:0] dat_now = {dat_q[14:0], ser_din};
   wire in_addr = cnt_q < mrx_pkg::SER_ADDR_LAST;
   wire at_addr = cnt_q == mrx_pkg::SER_ADDR_LAST;
   wire reading = addr_q == mrx_pkg::ADDR_RXB;
   wire byte_reg = addr_q == mrx_pkg::ADDR_TXB ||
      addr_q == mrx_pkg::ADDR_TXB_OS;
   wire word_reg = addr_q == mrx_pkg::ADDR_RXCFG ||
      addr_q == mrx_pkg::ADDR_GCTL;
   wire cmd_done = at_addr && addr_now == mrx_pkg::ADDR_GRESET;
   wire byte_done = byte_reg && cnt_q == mrx_pkg::SER_BYTE_LAST;
   wire word_done = word_reg && cnt_q == mrx_pkg::SER_WORD_LAST;
   wire rd_shift = reading && cnt_q > mrx_pkg::SER_ADDR_LAST &&
      cnt_q < mrx_pkg::SER_BYTE_LAST;
   wire rd_done = reading && cnt_q == mrx_pkg::SER_BYTE_LAST;
   wire [2:0] rd_idx = 3'(mrx_pkg::SER_RD_TOP - cnt_q);

   // Frame position and reply bit end with the frame's own select.
   always_ff @(posedge ser_clk or posedge ser_cs_n) begin
      if (ser_cs_n) begin
         cnt_q <= 5'h00;
         ser_dout_q <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
         if (at_addr && addr_now == mrx_pkg::ADDR_RXB) begin
            ser_dout_q <= snap_q[7];
         end else if (rd_shift) begin
            ser_dout_q <= snap_q[rd_idx];
         end else begin
            ser_dout_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ser_clk) begin
      if (in_addr || at_addr) begin
         addr_q <= addr_now;
      end else begin
         dat_q <= dat_now;
      end
      if (cmd_done || byte_done || word_done) begin
         wr_addr_q <= cmd_done ? addr_now : addr_q;
         wr_data_q <= cmd_done ? 16'h0000 : dat_now;
         wr_tgl_q <= ~wr_tgl_q;
      end
      if (rd_done) begin
         rd_tgl_q <= ~rd_tgl_q;
      end
      if (pub_pulse) begin
         snap_q <= pub_word_q;
         ack_tgl_q <= ~ack_tgl_q;
      end
   end

   assign ser_dout = ser_dout_q;

   // ********************************************************************
   // Crossings between the two clocks
   // ********************************************************************
   logic wr_pulse;
   logic rd_pulse;
   logic ack_pulse;

   mrx_tgl_sync u_wr_sync (.clk(ref_clk), .tgl_in(wr_tgl_q), .pulse(wr_pulse));
   mrx_tgl_sync u_rd_sync (.clk(ref_clk), .tgl_in(rd_tgl_q), .pulse(rd_pulse));
   mrx_tgl_sync u_ack_sync (
      .clk(ref_clk),
      .tgl_in(ack_tgl_q),
      .pulse(ack_pulse)
   );
   mrx_tgl_sync u_pub_sync (
      .clk(ser_clk),
      .tgl_in(pub_tgl_q),
      .pulse(pub_pulse)
   );

   // ********************************************************************
   // Register writes, reference clock domain
   // ********************************************************************
   logic [15:0] cfg_q;
   logic gctl_rst_q;

   wire wr_greset = wr_pulse && wr_addr_q == mrx_pkg::ADDR_GRESET;
   wire wr_gctl = wr_pulse && wr_addr_q == mrx_pkg::ADDR_GCTL;
   wire wr_cfg = wr_pulse && wr_addr_q == mrx_pkg::ADDR_RXCFG;
   wire wr_txb = wr_pulse && (wr_addr_q == mrx_pkg::ADDR_TXB ||
      wr_addr_q == mrx_pkg::ADDR_TXB_OS);
   wire wr_os = wr_addr_q == mrx_pkg::ADDR_TXB_OS;
   wire clr_all = rst || wr_greset || gctl_rst_q;

   always_ff @(posedge ref_clk) begin
      if (rst || wr_greset) begin
         gctl_rst_q <= 1'b0;
      end else if (wr_gctl) begin
         gctl_rst_q <= wr_data_q[mrx_pkg::GCTL_RST_BIT];
      end
      if (clr_all) begin
         cfg_q <= mrx_pkg::RXCFG_RESET;
      end else if (wr_cfg) begin
         cfg_q <= wr_data_q;
      end
   end

   // ********************************************************************
   // Receive configuration decode
   // ********************************************************************
   assign rx_cfg = mrx_pkg::mrx_rx_cfg_t'(cfg_q);
   assign auto_equaliser_enable = rx_cfg.eq;
   assign descrambler_enable = rx_cfg.desc[1];
   assign ones64_detect_enable = rx_cfg.desc[1] && rx_cfg.desc[0];
   assign tone_detect_active = rx_cfg.mode == mrx_pkg::MODE_TONE;
   assign tone_detector_select = tone_detect_active ? rx_cfg.fmt : 3'h0;

   // ********************************************************************
   // Receive character path and status
   // ********************************************************************
   logic char_stb;
   logic [7:0] char_data;
   logic fe_pulse;
   logic even_par;
   logic ready_q;
   logic ovf_q;
   logic fe_q;
   logic pub_busy_q;
   logic pub_pend_q;
   logic [7:0] rx_byte_q;

   mrx_rx_usart u_rx (
      .ref_clk(ref_clk),
      .rst(clr_all),
      .cfg(rx_cfg),
      .bit_in(demod_bit),
      .bit_stb(demod_bit_stb),
      .char_stb(char_stb),
      .char_data(char_data),
      .framing_err(fe_pulse),
      .even_par(even_par)
   );

   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         ready_q <= 1'b0;
         ovf_q <= 1'b0;
         fe_q <= 1'b0;
         rx_byte_q <= 8'h00;
      end else begin
         // A new character wins over a read in the same cycle.
         ready_q <= char_stb || (ready_q && !rd_pulse);
         ovf_q <= (char_stb && ready_q && !rd_pulse) ||
            (ovf_q && !rd_pulse);
         fe_q <= fe_pulse || (fe_q && !rd_pulse);
         if (char_stb) begin
            rx_byte_q <= char_data;
         end
      end
   end

   // The byte is handed to the bus side one word at a time, waiting for
   // the acknowledge before the published copy changes again.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pub_tgl_q <= 1'b0;
         pub_busy_q <= 1'b0;
         pub_pend_q <= 1'b0;
         pub_word_q <= 8'h00;
      end else if (!pub_busy_q && (pub_pend_q || char_stb)) begin
         pub_word_q <= char_stb ? char_data : rx_byte_q;
         pub_tgl_q <= ~pub_tgl_q;
         pub_busy_q <= 1'b1;
         pub_pend_q <= 1'b0;
      end else begin
         pub_busy_q <= pub_busy_q && !ack_pulse;
         pub_pend_q <= pub_pend_q || char_stb;
      end
   end

   assign rx_status = '{ready: ready_q, overflow: ovf_q,
      framing_error: fe_q, even_parity: even_par};

   // ********************************************************************
   // Transmit byte buffer and serialiser
   // ********************************************************************
   logic [7:0] hold_q;
   logic hold_full_q;
   logic hold_os_q;
   logic [11:0] frame_q;
   logic [3:0] left_q;
   logic tx_bit_q;
   logic [11:0] frame_d;
   logic [3:0] len_d;

   wire [3:0] n_tx = tx_fmt.sync ? mrx_pkg::LEN_SYNC :
      mrx_pkg::LEN_BASE + {2'h0, tx_fmt.len};
   wire load = hold_full_q && left_q == 4'h0;
   wire par_bit = ^(hold_q & (8'hFF >> (mrx_pkg::LEN_SYNC - n_tx))) ^
      tx_fmt.par_odd;

   // Builds the whole character LSB first: start, data, parity, then stops unless overspeed; a synchronous character is data only.
   always_comb begin
      frame_d = 12'hFFF;
      len_d = n_tx;
      if (tx_fmt.sync) begin
         frame_d[7:0] = hold_q;
      end else begin
         frame_d[0] = 1'b0;
         for (int i = 0; i < 8; i++) begin
            if (4'(i) < n_tx) begin
               frame_d[i + 1] = hold_q[i];
            end
         end
         len_d = n_tx + 4'h1;
         if (tx_fmt.par_en) begin
            frame_d[len_d] = par_bit;
            len_d = len_d + 4'h1;
         end
         if (!hold_os_q) begin
            // An overspeed character drops its stop bits.
            len_d = len_d + (tx_fmt.two_stop ? 4'h2 : 4'h1);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         hold_full_q <= 1'b0;
         hold_os_q <= 1'b0;
         hold_q <= 8'h00;
         frame_q <= 12'hFFF;
         left_q <= 4'h0;
         tx_bit_q <= 1'b1;
      end else begin
         if (wr_txb) begin
            hold_q <= wr_data_q[7:0];
            hold_os_q <= wr_os;
            hold_full_q <= 1'b1;
         end else if (load && tx_bit_stb) begin
            hold_full_q <= 1'b0;
         end
         if (tx_bit_stb) begin
            if (load) begin
               tx_bit_q <= frame_d[0];
               frame_q <= {1'b1, frame_d[11:1]};
               left_q <= len_d - 4'h1;
            end else if (left_q != 4'h0) begin
               tx_bit_q <= frame_q[0];
               frame_q <= {1'b1, frame_q[11:1]};
               left_q <= left_q - 4'h1;
            end else begin
               tx_bit_q <= 1'b1;
            end
         end
      end
   end

   assign tx_bit = tx_bit_q;
   assign tx_ready = !hold_full_q;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_cfg_cleared;
      gctl_rst_q |=> cfg_q == 16'h0000;
   endproperty
   a_cfg_cleared: assert property (p_cfg_cleared)
      else $error("Receive configuration not cleared by reset bit.");

   property p_cfg_write;
      wr_cfg && !gctl_rst_q |=> rx_cfg == $past(wr_data_q);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("Receive configuration write not stored.");

   property p_desc_decode;
      descrambler_enable == cfg_q[7] && ones64_detect_enable == &cfg_q[7:6]
         && auto_equaliser_enable == cfg_q[8];
   endproperty
   a_desc_decode: assert property (p_desc_decode)
      else $error("Equaliser or descrambler decode wrong.");

   property p_ready_set;
      char_stb && !clr_all |=> ready_q && rx_byte_q == $past(char_data);
   endproperty
   a_ready_set: assert property (p_ready_set)
      else $error("Received character did not raise data ready.");

   property p_ready_clear;
      rd_pulse && !char_stb |=> !ready_q;
   endproperty
   a_ready_clear: assert property (p_ready_clear)
      else $error("Receive byte read did not clear data ready.");

   sequence s_tx_load;
      load && tx_bit_stb && !tx_fmt.sync && !clr_all && !wr_txb;
   endsequence
   sequence s_start_out;
      !tx_bit && tx_ready ##0 left_q != 4'h0;
   endsequence
   property p_tx_start;
      s_tx_load |=> s_start_out;
   endproperty
   a_tx_start: assert property (p_tx_start)
      else $error("Start-stop character did not begin with a start bit.");

   property p_tx_sync_lsb;
      load && tx_bit_stb && tx_fmt.sync && !clr_all |=>
         tx_bit == $past(hold_q[0]) && left_q == 4'h7;
   endproperty
   a_tx_sync_lsb: assert property (p_tx_sync_lsb)
      else $error("Synchronous byte did not start with bit 0.");

   property p_tx_take;
      wr_txb && !clr_all |=> !tx_ready;
   endproperty
   a_tx_take: assert property (p_tx_take)
      else $error("Transmit byte write did not fill the buffer.");
endmodule

// ---- verification/mrx_host_model.sv ----
// Host model that runs frames on the serial control bus.
module mrx_host_model (
   output logic ser_clk,
   output logic ser_cs_n,
   output logic ser_din,
   input wire logic ser_dout
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      ser_clk = 1'b0;
      ser_cs_n = 1'b1;
      ser_din = 1'b0;
   end

   // The link clock idles low and runs only inside a frame.
   task automatic xfer(input logic [7:0] a, input logic [15:0] d,
                       input int n, output logic [7:0] r);
      logic [23:0] sh;
      sh = {a, d};
      r = 8'h00;
      ser_cs_n = 1'b0;
      for (int i = 0; i < 8 + n; i++) begin
         ser_din = sh[23 - i];
         #62.5;
         if (i >= 8) r = {r[6:0], ser_dout};
         ser_clk = 1'b1;
         #62.5 ser_clk = 1'b0;
      end
      // A released data line must not keep its last level.
      ser_din = ~ser_din;
      #62.5 ser_cs_n = 1'b1;
      #250;
   endtask
endmodule

// ---- verification/test_modem_rx_mode_and_data_regs.sv ----
// Self-checking bench for the receive mode and data registers.
module test_modem_rx_mode_and_data_regs;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic ser_clk, ser_cs_n, ser_din, ser_dout, tx_bit, tx_ready;
   logic tx_bit_stb = 1'b0;
   logic demod_bit = 1'b1;
   logic demod_bit_stb = 1'b0;
   logic auto_equaliser_enable, descrambler_enable, ones64_detect_enable;
   logic tone_detect_active;
   logic [2:0] tone_detector_select;
   mrx_pkg::mrx_tx_fmt_t tx_fmt = '0;
   mrx_pkg::mrx_rx_cfg_t rx_cfg;
   mrx_pkg::mrx_rx_stat_t rx_status;
   logic [31:0] seed = 32'h9E082B10;
   logic [15:0] v;
   logic [7:0] rd;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   int good = 0;

   always #2 ref_clk = ~ref_clk;

   mrx_top u_dut (.ref_clk, .rst, .ser_clk, .ser_cs_n, .ser_din, .ser_dout,
      .tx_fmt, .tx_bit_stb, .tx_bit, .tx_ready, .demod_bit, .demod_bit_stb,
      .rx_cfg, .auto_equaliser_enable, .descrambler_enable,
      .ones64_detect_enable, .tone_detect_active, .tone_detector_select,
      .rx_status);
   mrx_host_model u_host (.ser_clk, .ser_cs_n, .ser_din, .ser_dout);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk_v(input string nm, input logic [15:0] e,
                        input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_f(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic rxb(input logic b);
      @(posedge ref_clk);
      #1 demod_bit = b;
      demod_bit_stb = 1'b1;
      @(posedge ref_clk);
      #1 demod_bit_stb = 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic rx_char(input logic [2:0] fmt, input logic stop,
                          input logic [2:0] u);
      logic [7:0] d, m;
      logic p, tol;
      d = 8'(rnd());
      p = seed[3];
      m = 8'hFF >> (3 - fmt[2:1]);
      // A missing stop bit is forgiven after enough good characters.
      tol = !stop && ((u == 3'h5 && good >= 7) || (u == 3'h4 && good >= 3));
      u_host.xfer(8'hE2, {8'hDF, 2'b11, u, fmt}, 16, rd);
      repeat (10) rxb(1'b1);
      rxb(1'b0);
      for (int i = 0; i < 5 + fmt[2:1]; i++) rxb(d[i]);
      if (fmt[0]) rxb(p);
      rxb(stop);
      chk_f("ready", 1'b1, rx_status.ready);
      chk_f("framing", !stop && !tol, rx_status.framing_error);
      if (fmt[0]) chk_f("parity", ~^{d & m, p}, rx_status.even_parity);
      u_host.xfer(8'hE5, 16'h0000, 8, rd);
      chk_v("rx byte", 16'(d & m), 16'(rd));
      chk_f("ready clear", 1'b0, rx_status.ready);
      good = stop ? good + 1 : 0;
      if (tol) begin
         // The forgiven stop slot opened the next character: finish it.
         for (int i = 0; i < 6 + fmt[2:1] + fmt[0]; i++) rxb(1'b1);
         chk_f("ready os", 1'b1, rx_status.ready);
         u_host.xfer(8'hE5, 16'h0000, 8, rd);
         chk_v("os byte", 16'(m), 16'(rd));
         good = 1;
      end
   endtask

   task automatic tx_char(input logic [7:0] a, input logic sy);
      logic [7:0] d, m;
      logic [15:0] e;
      mrx_pkg::mrx_tx_fmt_t f;
      int k;
      d = 8'(rnd());
      e = 16'hFFFF;
      f = 6'(rnd());
      f.sync = sy;
      m = sy ? 8'hFF : 8'hFF >> (3 - f.len);
      k = sy ? 0 : 1;
      e[0] = sy ? d[0] : 1'b0;
      @(posedge ref_clk);
      #1 tx_fmt = f;
      for (int i = 0; i < 100 && tx_ready !== 1'b1; i++) @(posedge ref_clk);
      u_host.xfer(a, {d, 8'h00}, 8, rd);
      for (int i = 0; i < 8; i++) if (m[i]) e[k + i] = d[i];
      k = k + (sy ? 8 : 5 + f.len);
      if (!sy && f.par_en) begin
         e[k] = ^(d & m) ^ f.par_odd;
         k++;
      end
      if (!sy && a == 8'hE3) k = k + 1 + f.two_stop;
      for (int j = 0; j < k; j++) begin
         @(posedge ref_clk);
         #1 tx_bit_stb = 1'b1;
         @(posedge ref_clk);
         #1 tx_bit_stb = 1'b0;
         chk_f("tx bit", e[j], tx_bit);
      end
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge ref_clk);
      chk_v("cfg reset", 16'h0000, rx_cfg);
      chk_f("tx ready", 1'b1, tx_ready);
      chk_f("tx idle", 1'b1, tx_bit);
      for (int md = 0; md < 14; md++) begin
         v = 16'(rnd());
         v[15:12] = 4'(md);
         if (md >= 2 && md <= 9) v[8:6] = 3'h0;
         if (md == 1) v[8:3] = 6'h00;
         if (md == 0) v[11:0] = 12'h000;
         u_host.xfer(8'hE2, v, 16, rd);
         chk_v("rx_cfg", v, rx_cfg);
         chk_f("equaliser", v[8], auto_equaliser_enable);
         chk_f("descrambler", v[7], descrambler_enable);
         chk_f("ones64", v[7] & v[6], ones64_detect_enable);
         chk_f("tone", md == 1, tone_detect_active);
         chk_v("tone sel", md == 1 ? v[2:0] : 0, 16'(tone_detector_select));
      end
      u_host.xfer(8'hE2, 16'h0000, 16, rd);
      chk_v("cfg read", 16'h0000, 16'(rd));
      u_host.xfer(8'hE3, 16'h0000, 8, rd);
      chk_v("tx read", 16'h0000, 16'(rd));
      u_host.xfer(8'hE0, 16'h0080, 16, rd);
      chk_v("cfg gctl", 16'h0000, rx_cfg);
      u_host.xfer(8'hE2, 16'hD7F6, 16, rd);
      chk_v("cfg held", 16'h0000, rx_cfg);
      u_host.xfer(8'hE0, 16'h0000, 16, rd);
      u_host.xfer(8'hE2, 16'hD7F6, 16, rd);
      chk_v("cfg write", 16'hD7F6, rx_cfg);
      u_host.xfer(8'h01, 16'h0000, 0, rd);
      chk_v("cfg greset", 16'h0000, rx_cfg);
      v = 16'(rnd());
      u_host.xfer(8'hE2, {8'hC0, 5'h07, v[2:0]}, 16, rd);
      for (int i = 0; i < 8; i++) rxb(v[8 + i]);
      chk_f("sync ready", 1'b1, rx_status.ready);
      u_host.xfer(8'hE5, 16'h0000, 8, rd);
      chk_v("sync byte", 16'(v[15:8]), 16'(rd));
      for (int i = 0; i < 16; i++) rxb(v[8 + i % 8]);
      chk_f("overflow", 1'b1, rx_status.overflow);
      u_host.xfer(8'hE5, 16'h0000, 8, rd);
      chk_f("overflow clear", 1'b0, rx_status.overflow);
      for (int f = 0; f < 8; f++) rx_char(3'(f), 1'b1, 3'h6);
      rx_char(3'h6, 1'b0, 3'h6);
      repeat (3) rx_char(3'h6, 1'b1, 3'h4);
      rx_char(3'h6, 1'b0, 3'h4);
      repeat (4) tx_char(8'hE3, 1'b0);
      tx_char(8'hE3, 1'b1);
      tx_char(8'hE4, 1'b0);
      report_and_stop();
   end
endmodule
